// ===== hw/perf_event_consts.vh
// Event numbers, unit masks and widths for the event select counter.
// Assumes inclusion by the counter modules only; definitions only.
`ifndef PERF_EVENT_CONSTS_VH
`define PERF_EVENT_CONSTS_VH

`define CNT_WIDTH        40
`define SEL_WIDTH        8
`define ADDR_WIDTH       48
`define INC_WIDTH        3

`define EV_LOAD_RETIRED  8'hcb
`define EV_FP_MM_TRANS   8'hcc
`define EV_VEC_ASSIST    8'hcd
`define EV_MM_VEC_RET    8'hce
`define EV_SAT_VEC_RET   8'hcf
`define EV_RENAME_STALL  8'hd2
`define EV_SEG_STALL     8'hd4
`define EV_SEG_RENAME    8'hd5
`define EV_RES_STALL     8'hdc
`define EV_BR_DECODED    8'he0
`define EV_FALSE_BRANCH  8'he4
`define EV_RESTEER       8'he6
`define EV_PREF_UP       8'hf0
`define EV_PREF_DN       8'hf8

`define UM_NONE          8'h00
`define UM_B0            8'h01
`define UM_B1            8'h02
`define UM_B2            8'h04
`define UM_B3            8'h08
`define UM_B4            8'h10
`define UM_ANY4          8'h0f
`define UM_ANY5          8'h1f

`define STATUS_WRITE_WEIGHT 3'h2
`define PRECISE_COUNTER  2'h0

`endif

// ===== hw/perf_count_accum.v
// Occurrence accumulator: adds a small increment per enabled clock.
// Assumes increment comes from logic on the same clock.
`timescale 1ns/10ps
module perf_count_accum #(
  parameter WIDTH = 40,
  parameter INC_W = 3
) (
  // Clock and control
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire             clear_i,
  // Increment
  input  wire [INC_W-1:0] inc_i,
  // Result
  output reg  [WIDTH-1:0] count_o,
  output reg              wrap_o
);

  wire [WIDTH:0] sum = {1'b0, count_o} + {{(WIDTH+1-INC_W){1'b0}}, inc_i};

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= {WIDTH{1'b0}};
      wrap_o  <= 1'b0;
    end else if (ce_i) begin
      if (clear_i) begin
        count_o <= {WIDTH{1'b0}};
        wrap_o  <= 1'b0;
      end else begin
        count_o <= sum[WIDTH-1:0];
        // Sticky so software can spot a lost carry
        wrap_o  <= wrap_o | sum[WIDTH];
      end
    end
  end

endmodule // perf_count_accum

// ===== hw/perf_event_select_counter.v
// Event select decode and counter for one performance counter slot.
// Assumes all condition inputs are pulses or levels on CLK_SYS_I.
`timescale 1ns/10ps
`include "perf_event_consts.vh"

// Function
// RULE1 - CBH/08H counts retired loads fetching lines
// RULE2 - Load miss events: cacheable, no software prefetch
// RULE3 - Precise sample holds next instruction address
// RULE4 - CBH/10H counts non-faulting translation buffer misses
// RULE5 - CCH counts float/multimedia first transitions
// RULE6 - CDH counts state-changing empty-state assists
// RULE7 - CEH/CFH count retired multimedia, saturating vectors
// RULE8 - D2H/01H counts reorder port stall cycles
// RULE9 - D2H/02H counts partial register latency cycles
// RULE10 - D2H/04H counts flag stall cycles
// RULE11 - D2H/08H adds two per status write
// RULE12 - D2H/0FH counts any rename table stall
// RULE13 - D4H counts segment rename resource stalls
// RULE14 - D5H counts segment renames, each or any
// RULE15 - DCH 01H/02H count buffer, station full
// RULE16 - DCH/04 counts load, store, fence stalls
// RULE17 - DCH/08H counts control word write stalls
// RULE18 - DCH/10H counts mispredict recovery cycles
// RULE19 - DCH/1FH counts any resource stall cycle
// RULE20 - E0H decoded branches; E4H false branch detects
// RULE21 - E6H counts front end resteers
// RULE22 - F0H/F8H count upward, downward prefetches
// RULE23 - Only matching event and mask counts
// RULE24 - Cycles add one; occurrences add count
module perf_event_select_counter (
  // Clock, reset, enable
  input  wire                   CLK_SYS_I,
  input  wire                   RST_I,
  input  wire                   CE_I,
  // Counter programming
  input  wire                   CONFIG_WE_I,
  input  wire [`SEL_WIDTH-1:0]  EVENT_SEL_I,
  input  wire [`SEL_WIDTH-1:0]  UMASK_I,
  input  wire [1:0]             COUNTER_IDX_I,
  input  wire                   COUNT_EN_I,
  input  wire                   COUNT_CLEAR_I,
  // Retired load conditions
  input  wire                   LOAD_RETIRE_I,
  input  wire                   LOAD_CACHEABLE_I,
  input  wire                   LOAD_SW_PREFETCH_I,
  input  wire                   LOAD_L2_LINE_FETCH_I,
  input  wire                   LOAD_XLATE_MISS_I,
  input  wire                   LOAD_FAULT_I,
  // Retired instruction stream, for precise samples
  input  wire                   INSTR_RETIRE_I,
  input  wire [`ADDR_WIDTH-1:0] INSTR_ADDR_I,
  // Float and multimedia execution
  input  wire                   FLOAT_INSTR_I,
  input  wire                   MM_INSTR_I,
  input  wire                   EMPTY_MM_STATE_INSTR_I,
  input  wire                   MM_VECTOR_RETIRE_I,
  input  wire                   SAT_VECTOR_RETIRE_I,
  // Rename table stalls
  input  wire                   REORDER_PORT_STALL_I,
  input  wire                   PARTIAL_REG_STALL_I,
  input  wire                   FLAG_STALL_I,
  input  wire                   FLOAT_STATUS_WRITE_I,
  // Segment rename, one bit per segment register
  input  wire [3:0]             SEG_RENAME_STALL_I,
  input  wire [3:0]             SEG_RENAME_I,
  // Resource stalls
  input  wire                   REORDER_BUFFER_FULL_I,
  input  wire                   STATION_FULL_I,
  input  wire                   LOAD_LIMIT_REACHED_I,
  input  wire                   STORE_LIMIT_REACHED_I,
  input  wire                   STORE_COMMIT_I,
  input  wire                   FENCE_WAITING_I,
  input  wire                   STORES_OUTSTANDING_I,
  input  wire                   FLOAT_CONTROL_WRITE_STALL_I,
  input  wire                   BRANCH_MISPREDICT_I,
  input  wire                   MISPREDICT_OLDER_RETIRED_I,
  // Front end and prefetch
  input  wire                   BRANCH_DECODED_I,
  input  wire                   FALSE_BRANCH_DETECT_I,
  input  wire                   FRONT_END_RESTEER_I,
  input  wire                   UPWARD_PREFETCH_I,
  input  wire                   DOWNWARD_PREFETCH_I,
  // Results
  output reg  [`CNT_WIDTH-1:0]  COUNT_O,
  output reg                    COUNT_WRAP_O,
  output reg                    EVENT_MATCH_O,
  output reg                    SAMPLE_VALID_O,
  output reg  [`ADDR_WIDTH-1:0] SAMPLE_ADDR_O
);

  // Programmed selection
  reg  [`SEL_WIDTH-1:0]  event_sel;
  reg  [`SEL_WIDTH-1:0]  umask;
  reg  [1:0]             counter_idx;
  reg                    count_en;

  // Pipeline state tracked here
  reg                    mm_mode;
  reg                    load_limit_stall;
  reg                    store_limit_stall;
  reg                    recovery_stall;
  reg                    sample_armed;

  // Decode results
  reg  [`INC_WIDTH-1:0]  next_inc;
  reg                    next_match;
  reg                    next_precise;
  reg                    next_hit;

  wire [`CNT_WIDTH-1:0]  accum_count;
  wire                   accum_wrap;

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      event_sel   <= 8'h00;
      umask       <= 8'h00;
      counter_idx <= 2'h0;
      count_en    <= 1'b0;
    end else if (CE_I && CONFIG_WE_I) begin
      event_sel   <= EVENT_SEL_I;
      umask       <= UMASK_I;
      counter_idx <= COUNTER_IDX_I;
      count_en    <= COUNT_EN_I;
    end
  end

  // Qualified load: cacheable and not from a software prefetch
  wire load_ok  = LOAD_RETIRE_I & LOAD_CACHEABLE_I &
                  ~LOAD_SW_PREFETCH_I; // RULE2
  wire l2_fetch = load_ok & LOAD_L2_LINE_FETCH_I; // RULE1
  // A faulting load does not record its translation miss
  wire xl_miss  = load_ok & LOAD_XLATE_MISS_I & ~LOAD_FAULT_I; // RULE4

  // Transition detection needs the last executed class
  wire to_mm    = MM_INSTR_I & ~mm_mode; // RULE5
  wire to_float = FLOAT_INSTR_I & mm_mode; // RULE5
  // Assist only fires when the empty-state instruction flips the stack
  wire assist   = EMPTY_MM_STATE_INSTR_I & mm_mode; // RULE6

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mm_mode <= 1'b0;
    end else if (CE_I) begin
      if (EMPTY_MM_STATE_INSTR_I || FLOAT_INSTR_I) begin
        mm_mode <= 1'b0;
      end else if (MM_INSTR_I) begin
        mm_mode <= 1'b1;
      end
    end
  end

  // Load and store limit stalls end on retire and commit; a new
  // limit hit in the same cycle keeps the stall standing.
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      load_limit_stall  <= 1'b0;
      store_limit_stall <= 1'b0;
      recovery_stall    <= 1'b0;
    end else if (CE_I) begin
      load_limit_stall  <= LOAD_LIMIT_REACHED_I |
                           (load_limit_stall & ~LOAD_RETIRE_I); // RULE16
      store_limit_stall <= STORE_LIMIT_REACHED_I |
                           (store_limit_stall & ~STORE_COMMIT_I); // RULE16
      recovery_stall    <= BRANCH_MISPREDICT_I |
                           (recovery_stall &
                            ~MISPREDICT_OLDER_RETIRED_I); // RULE18
    end
  end

  wire fence_stall = FENCE_WAITING_I & STORES_OUTSTANDING_I; // RULE16
  wire ld_st_cycle = LOAD_LIMIT_REACHED_I | load_limit_stall |
                     STORE_LIMIT_REACHED_I | store_limit_stall |
                     fence_stall; // RULE16
  wire recov_cycle = BRANCH_MISPREDICT_I | recovery_stall; // RULE18

  wire rat_any = REORDER_PORT_STALL_I | PARTIAL_REG_STALL_I |
                 FLAG_STALL_I | FLOAT_STATUS_WRITE_I; // RULE12
  wire res_any = REORDER_BUFFER_FULL_I | STATION_FULL_I | ld_st_cycle |
                 FLOAT_CONTROL_WRITE_STALL_I | recov_cycle; // RULE19

  wire [2:0] seg_stall_sum = {2'b00, SEG_RENAME_STALL_I[0]} +
                             {2'b00, SEG_RENAME_STALL_I[1]} +
                             {2'b00, SEG_RENAME_STALL_I[2]} +
                             {2'b00, SEG_RENAME_STALL_I[3]};
  wire [2:0] seg_ren_sum   = {2'b00, SEG_RENAME_I[0]} +
                             {2'b00, SEG_RENAME_I[1]} +
                             {2'b00, SEG_RENAME_I[2]} +
                             {2'b00, SEG_RENAME_I[3]};

  // Each segment mask bit selects one register; all four sums them
  function [2:0] seg_pick;
    input [7:0] mask;
    input [3:0] bits;
    input [2:0] sum;
    begin
      case (mask)
        `UM_B0:   seg_pick = {2'b00, bits[0]};
        `UM_B1:   seg_pick = {2'b00, bits[1]};
        `UM_B2:   seg_pick = {2'b00, bits[2]};
        `UM_B3:   seg_pick = {2'b00, bits[3]};
        `UM_ANY4: seg_pick = sum;
        default:  seg_pick = 3'h0;
      endcase
    end
  endfunction

  function seg_mask_ok;
    input [7:0] mask;
    begin
      seg_mask_ok = (mask == `UM_B0) || (mask == `UM_B1) ||
                    (mask == `UM_B2) || (mask == `UM_B3) ||
                    (mask == `UM_ANY4);
    end
  endfunction

  always @* begin
    next_inc     = 3'h0;
    next_match   = 1'b0;
    next_precise = 1'b0;
    next_hit     = 1'b0;
    case (event_sel)
      `EV_LOAD_RETIRED: begin
        if (umask == `UM_B3) begin
          next_match   = 1'b1;
          next_precise = 1'b1;
          next_hit     = l2_fetch; // RULE1
        end else if (umask == `UM_B4) begin
          next_match   = 1'b1;
          next_precise = 1'b1;
          next_hit     = xl_miss; // RULE4
        end
        next_inc = {2'b00, next_hit};
      end
      `EV_FP_MM_TRANS: begin
        if (umask == `UM_B0) begin
          next_match = 1'b1;
          next_inc   = {2'b00, to_mm}; // RULE5
        end else if (umask == `UM_B1) begin
          next_match = 1'b1;
          next_inc   = {2'b00, to_float}; // RULE5
        end
      end
      `EV_VEC_ASSIST: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          next_inc   = {2'b00, assist}; // RULE6
        end
      end
      `EV_MM_VEC_RET: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          next_inc   = {2'b00, MM_VECTOR_RETIRE_I}; // RULE7
        end
      end
      `EV_SAT_VEC_RET: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          next_inc   = {2'b00, SAT_VECTOR_RETIRE_I}; // RULE7
        end
      end
      `EV_RENAME_STALL: begin
        next_match = 1'b1;
        case (umask)
          // Retried micro-ops raise the stall again, so every cycle counts
          `UM_B0:   next_inc = {2'b00, REORDER_PORT_STALL_I}; // RULE8
          `UM_B1:   next_inc = {2'b00, PARTIAL_REG_STALL_I}; // RULE9
          `UM_B2:   next_inc = {2'b00, FLAG_STALL_I}; // RULE10
          // Software halves this figure to get the write count
          `UM_B3:   next_inc = FLOAT_STATUS_WRITE_I ?
                               `STATUS_WRITE_WEIGHT : 3'h0; // RULE11
          `UM_ANY4: next_inc = {2'b00, rat_any}; // RULE12
          default:  next_match = 1'b0;
        endcase
      end
      `EV_SEG_STALL: begin
        next_match = seg_mask_ok(umask);
        next_inc   = seg_pick(umask, SEG_RENAME_STALL_I,
                              seg_stall_sum); // RULE13
      end
      `EV_SEG_RENAME: begin
        next_match = seg_mask_ok(umask);
        next_inc   = seg_pick(umask, SEG_RENAME_I, seg_ren_sum); // RULE14
      end
      `EV_RES_STALL: begin
        next_match = 1'b1;
        case (umask)
          `UM_B0:   next_inc = {2'b00, REORDER_BUFFER_FULL_I}; // RULE15
          `UM_B1:   next_inc = {2'b00, STATION_FULL_I}; // RULE15
          `UM_B2:   next_inc = {2'b00, ld_st_cycle}; // RULE16
          `UM_B3:   next_inc = {2'b00,
                                FLOAT_CONTROL_WRITE_STALL_I}; // RULE17
          `UM_B4:   next_inc = {2'b00, recov_cycle}; // RULE18
          `UM_ANY5: next_inc = {2'b00, res_any}; // RULE19
          default:  next_match = 1'b0;
        endcase
      end
      `EV_BR_DECODED: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          next_inc   = {2'b00, BRANCH_DECODED_I}; // RULE20
        end
      end
      `EV_FALSE_BRANCH: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          next_inc   = {2'b00, FALSE_BRANCH_DETECT_I}; // RULE20
        end
      end
      `EV_RESTEER: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          // A false branch detect always resteers; OR avoids double count
          next_inc   = {2'b00, FRONT_END_RESTEER_I |
                               FALSE_BRANCH_DETECT_I}; // RULE20 RULE21
        end
      end
      `EV_PREF_UP: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          next_inc   = {2'b00, UPWARD_PREFETCH_I}; // RULE22
        end
      end
      `EV_PREF_DN: begin
        if (umask == `UM_NONE) begin
          next_match = 1'b1;
          next_inc   = {2'b00, DOWNWARD_PREFETCH_I}; // RULE22
        end
      end
      default: begin
        next_match = 1'b0;
        next_inc   = 3'h0;
      end
    endcase
    // Load events are only wired to general counter zero
    if (next_precise && counter_idx != `PRECISE_COUNTER) begin
      next_match = 1'b0; // RULE1 RULE4
    end
    if (!next_match || !count_en) begin
      next_inc = 3'h0; // RULE23
      next_hit = 1'b0;
    end
  end

  // One add per clock covers both cycle and multi-occurrence events
  perf_count_accum #(
    .WIDTH (`CNT_WIDTH),
    .INC_W (`INC_WIDTH)
  ) u_accum (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .clear_i (COUNT_CLEAR_I),
    .inc_i   (next_inc), // RULE24
    .count_o (accum_count),
    .wrap_o  (accum_wrap)
  );

  // Precise sample: the address recorded is that of the next
  // instruction to retire after the one that hit, not the hitter.
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sample_armed   <= 1'b0;
      SAMPLE_VALID_O <= 1'b0;
      SAMPLE_ADDR_O  <= {`ADDR_WIDTH{1'b0}};
    end else if (CE_I) begin
      SAMPLE_VALID_O <= 1'b0;
      if (sample_armed && INSTR_RETIRE_I) begin
        SAMPLE_VALID_O <= 1'b1; // RULE3
        SAMPLE_ADDR_O  <= INSTR_ADDR_I; // RULE3
      end
      if (next_hit && next_precise) begin
        sample_armed <= 1'b1;
      end else if (INSTR_RETIRE_I) begin
        sample_armed <= 1'b0;
      end
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      COUNT_O       <= {`CNT_WIDTH{1'b0}};
      COUNT_WRAP_O  <= 1'b0;
      EVENT_MATCH_O <= 1'b0;
    end else if (CE_I) begin
      COUNT_O       <= accum_count;
      COUNT_WRAP_O  <= accum_wrap;
      EVENT_MATCH_O <= next_match;
    end
  end

endmodule // perf_event_select_counter

// ===== tb/pipe_cond_model.sv
// Pipeline condition source that faces the counter's inputs.
// Assumes the bench updates word_i shortly after a rising clock edge.
`timescale 1ns/10ps
module pipe_cond_model (
  // Stimulus from the bench
  input  wire [37:0] word_i,
  // Condition lines to the counter
  output wire [38:0] cond_o
);
  // One instruction per slot, so float, multimedia and empty-state
  // classes never coincide; the mode tracking relies on that
  assign cond_o = {word_i[37:9], word_i[8:7] == 2'h3,
                   word_i[8:7] == 2'h2, word_i[8:7] == 2'h1, word_i[6:0]};
endmodule // pipe_cond_model

// ===== tb/perf_event_select_counter_checker.sv
// Port-level checks of the event select counter.
// Assumes bind to the top module; one clock, synchronous reset.
`timescale 1ns/10ps
module perf_event_select_counter_checker (
  // Clock and control
  input wire        CLK_SYS_I,
  input wire        RST_I,
  input wire        CE_I,
  input wire        CONFIG_WE_I,
  input wire [7:0]  EVENT_SEL_I,
  input wire [7:0]  UMASK_I,
  input wire [1:0]  COUNTER_IDX_I,
  input wire        COUNT_EN_I,
  input wire        COUNT_CLEAR_I,
  // Watched conditions
  input wire        BRANCH_DECODED_I,
  input wire        FLOAT_STATUS_WRITE_I,
  // Results
  input wire [39:0] COUNT_O,
  input wire        EVENT_MATCH_O,
  input wire        SAMPLE_VALID_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Shadow of the selection; age hides the match pipeline after a write
  reg  [7:0] hev;
  reg  [7:0] hum;
  reg        hen;
  reg  [1:0] age;
  wire       quiet;
  always @(posedge CLK_SYS_I) begin
    if (RST_I)
      {hev, hum, hen, age} <= 19'h0;
    else if (CE_I && CONFIG_WE_I)
      {hev, hum, hen, age} <= {EVENT_SEL_I, UMASK_I, COUNT_EN_I, 2'h0};
    else if (CE_I && age != 2'h3)
      age <= age + 2'h1;
  end
  assign quiet = age == 2'h3 && CE_I && !CONFIG_WE_I && !COUNT_CLEAR_I;

  AST_RESET_ZERO: assert property (disable iff (1'b0) RST_I |=>
    COUNT_O == 40'h0 && !EVENT_MATCH_O && !SAMPLE_VALID_O)
    else $error("outputs not cleared by reset");
  AST_CE_FREEZE: assert property (!CE_I |=> $stable(COUNT_O))
    else $error("count moved with clock enable low");
  AST_CLEAR: assert property (CE_I && COUNT_CLEAR_I ##1 CE_I |=>
    COUNT_O == 40'h0) else $error("clear did not zero the count");
  AST_KNOWN_MATCH: assert property (CE_I && CONFIG_WE_I &&
    EVENT_SEL_I == 8'he6 && UMASK_I == 8'h00 ##1 CE_I && !CONFIG_WE_I
    |=> EVENT_MATCH_O) else $error("known pair not matched");
  AST_LOAD_IDX: assert property (CE_I && CONFIG_WE_I &&
    EVENT_SEL_I == 8'hcb && UMASK_I == 8'h08 && COUNTER_IDX_I != 2'h0
    ##1 CE_I && !CONFIG_WE_I |=> !EVENT_MATCH_O)
    else $error("load event matched on a nonzero slot");
  AST_UNKNOWN_MATCH: assert property (CE_I && CONFIG_WE_I &&
    EVENT_SEL_I == 8'h00 ##1 CE_I && !CONFIG_WE_I |=> !EVENT_MATCH_O)
    else $error("unknown pair matched");
  AST_FROZEN: assert property (quiet &&
    (!hen || !EVENT_MATCH_O) ##1 CE_I |=> $stable(COUNT_O))
    else $error("count moved without a matching selection");
  AST_DECODED_ADD: assert property (quiet && hen &&
    hev == 8'he0 && hum == 8'h00 ##1 CE_I |=>
    COUNT_O == $past(COUNT_O) + $past(BRANCH_DECODED_I, 2))
    else $error("decoded branch count off");
  AST_STATUS_DOUBLE: assert property (quiet && hen &&
    hev == 8'hd2 && hum == 8'h08 ##1 CE_I |=>
    COUNT_O == $past(COUNT_O) + {$past(FLOAT_STATUS_WRITE_I, 2), 1'b0})
    else $error("status write did not add two");
endmodule // perf_event_select_counter_checker

bind perf_event_select_counter perf_event_select_counter_checker u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CE_I(CE_I),
  .CONFIG_WE_I(CONFIG_WE_I), .EVENT_SEL_I(EVENT_SEL_I),
  .UMASK_I(UMASK_I), .COUNTER_IDX_I(COUNTER_IDX_I),
  .COUNT_EN_I(COUNT_EN_I), .COUNT_CLEAR_I(COUNT_CLEAR_I),
  .BRANCH_DECODED_I(BRANCH_DECODED_I),
  .FLOAT_STATUS_WRITE_I(FLOAT_STATUS_WRITE_I), .COUNT_O(COUNT_O),
  .EVENT_MATCH_O(EVENT_MATCH_O), .SAMPLE_VALID_O(SAMPLE_VALID_O));

// ===== tb/perf_event_select_counter_tb_top.sv
// Self-checking bench for the event select counter.
// Assumes the counter, its checker and the condition model are compiled.
`timescale 1ns/10ps
module perf_event_select_counter_tb_top;
  // Entry: match, {0, disabled, slot}, event, mask
  localparam NC = 38;
  localparam [NC*24-1:0] TAB = {24'h10cb08, 24'h10cb10, 24'h01cb08,
    24'h10cc01, 24'h10cc02, 24'h10cd00, 24'h10ce00, 24'h10cf00,
    24'h10d201, 24'h10d202, 24'h10d204, 24'h10d208, 24'h10d20f,
    24'h10d401, 24'h10d402, 24'h10d404, 24'h10d408, 24'h10d40f,
    24'h10d501, 24'h10d502, 24'h10d504, 24'h10d508, 24'h10d50f,
    24'h10dc01, 24'h10dc02, 24'h10dc04, 24'h10dc08, 24'h10dc10,
    24'h10dc1f, 24'h10e000, 24'h10e400, 24'h10e600, 24'h10f000,
    24'h10f800, 24'h14e600, 24'h00cb01, 24'h000000, 24'h03cb10};
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         ce = 1'b1;
  reg         we = 1'b0;
  reg         en = 1'b0;
  reg         clr = 1'b0;
  reg  [1:0]  idx = 2'h0;
  reg  [7:0]  ev = 8'h00;
  reg  [7:0]  um = 8'h00;
  reg  [37:0] w = 38'h0;
  reg  [47:0] a = 48'h0;
  reg  [63:0] rv;
  reg  [23:0] t = 24'h0;
  reg  [15:0] mcfg;
  reg         men, mmt, lsl, ssl, msl, mmode;
  reg  [4:0]  r;
  wire [38:0] c;
  wire [39:0] cnt;
  wire [47:0] sa;
  wire        mt, sv, wr;
  integer     failures = 0;
  integer     compares = 0;
  integer     cyc = 0;
  integer     exp, pe, k, i, n;

  always #4 clk = ~clk;

  pipe_cond_model u_pm (.word_i(w), .cond_o(c));

  perf_event_select_counter dut (
    .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .CONFIG_WE_I(we),
    .EVENT_SEL_I(ev), .UMASK_I(um), .COUNTER_IDX_I(idx),
    .COUNT_EN_I(en), .COUNT_CLEAR_I(clr), .LOAD_RETIRE_I(c[0]),
    .LOAD_CACHEABLE_I(c[1]), .LOAD_SW_PREFETCH_I(c[2]),
    .LOAD_L2_LINE_FETCH_I(c[3]), .LOAD_XLATE_MISS_I(c[4]),
    .LOAD_FAULT_I(c[5]), .INSTR_RETIRE_I(c[6]), .INSTR_ADDR_I(a),
    .FLOAT_INSTR_I(c[7]), .MM_INSTR_I(c[8]),
    .EMPTY_MM_STATE_INSTR_I(c[9]), .MM_VECTOR_RETIRE_I(c[10]),
    .SAT_VECTOR_RETIRE_I(c[11]), .REORDER_PORT_STALL_I(c[12]),
    .PARTIAL_REG_STALL_I(c[13]), .FLAG_STALL_I(c[14]),
    .FLOAT_STATUS_WRITE_I(c[15]), .SEG_RENAME_STALL_I(c[19:16]),
    .SEG_RENAME_I(c[23:20]), .REORDER_BUFFER_FULL_I(c[24]),
    .STATION_FULL_I(c[25]), .LOAD_LIMIT_REACHED_I(c[26]),
    .STORE_LIMIT_REACHED_I(c[27]), .STORE_COMMIT_I(c[28]),
    .FENCE_WAITING_I(c[29]), .STORES_OUTSTANDING_I(c[30]),
    .FLOAT_CONTROL_WRITE_STALL_I(c[31]), .BRANCH_MISPREDICT_I(c[32]),
    .MISPREDICT_OLDER_RETIRED_I(c[33]), .BRANCH_DECODED_I(c[34]),
    .FALSE_BRANCH_DETECT_I(c[35]), .FRONT_END_RESTEER_I(c[36]),
    .UPWARD_PREFETCH_I(c[37]), .DOWNWARD_PREFETCH_I(c[38]),
    .COUNT_O(cnt), .COUNT_WRAP_O(wr), .EVENT_MATCH_O(mt),
    .SAMPLE_VALID_O(sv), .SAMPLE_ADDR_O(sa));

  function integer pc(input [3:0] v);
    pc = v[0] + v[1] + v[2] + v[3];
  endfunction

  // Reference count: stall latches run whatever is selected
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      failures = failures + 1;
      test_done;
    end
    if (rst) begin
      {exp, pe, lsl, ssl, msl, mmode} = 68'h0;
      {mcfg, mmt, men} = 18'h0;
    end else if (ce) begin
      if (we)
        {mcfg, mmt, men} = {ev, um, t[20], en};
      r = {c[32] | msl, c[31], c[26] | lsl | c[27] | ssl | (c[29] & c[30]),
           c[25], c[24]};
      case (mcfg[15:8])
        8'hcb: k = mcfg[4] ? c[0] & c[1] & ~c[2] & c[4] & ~c[5]
                           : c[0] & c[1] & ~c[2] & c[3];
        8'hcc: k = mcfg[0] ? c[8] & ~mmode : c[7] & mmode;
        8'hcd: k = c[9] & mmode;
        8'hce: k = c[10];
        8'hcf: k = c[11];
        8'hd2: k = mcfg[3:0] == 4'h8 ? 2 * c[15]
                 : |(c[15:12] & mcfg[3:0]);
        8'hd4: k = pc(c[19:16] & mcfg[3:0]);
        8'hd5: k = pc(c[23:20] & mcfg[3:0]);
        8'hdc: k = |(r & mcfg[4:0]);
        8'he0: k = c[34];
        8'he4: k = c[35];
        8'he6: k = c[36] | c[35];
        8'hf0: k = c[37];
        8'hf8: k = c[38];
        default: k = 0;
      endcase
      // Output register trails the accumulator by one enabled edge
      pe = exp;
      exp = clr ? 0 : exp + (mmt & men ? k : 0);
      lsl = c[26] | (lsl & ~c[0]);
      ssl = c[27] | (ssl & ~c[28]);
      msl = c[32] | (msl & ~c[33]);
      mmode = c[8] | (mmode & ~c[7] & ~c[9]);
    end
  end

  // The last edge drives nothing, so the caller sets the next request
  task step(input integer m, input rnd);
    integer j;
    for (j = 0; j < m; j = j + 1) begin
      @(posedge clk);
      #1;
      if (j < m - 1) begin
        rv = {$urandom, $urandom};
        we = 1'b0;
        w = rnd ? rv[37:0] : 38'h0;
        a = rnd ? rv[47:0] : a;
        ce = !rnd || ($urandom % 8 != 0);
        clr = rnd && ($urandom % 64 == 0);
      end
    end
  endtask

  task chk(input [47:0] got, input [47:0] want);
    begin
      compares = compares + 1;
      if (got !== want) begin
        failures = failures + 1;
        $display("Error t=%0t got %0h exp %0h", $time, got, want);
      end
    end
  endtask

  task test_done;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial begin
    n = $urandom(11);
    step(3, 0);
    rst = 1'b0;
    chk(cnt, 48'h0);
    chk(mt, 48'h0);
    for (i = 0; i < NC; i = i + 1) begin
      t = TAB[(NC - 1 - i) * 24 +: 24];
      {ev, um, idx, en} = {t[15:0], t[17:16], !t[18]};
      {we, clr} = 2'h3;
      step(4, 0);
      chk(mt, t[20]);
      step(200, 1);
      step(3, 0);
      chk(cnt, pe);
    end
    // Retire in the hit cycle is skipped; the next one is sampled
    {ev, um, idx, en, we} = {16'hcb08, 2'h0, 2'h3};
    t = 24'h10cb08;
    step(4, 0);
    {w, a} = {38'h4b, 48'h1111_1111_1111};
    step(1, 0);
    {w, a} = {38'h40, 48'h2222_2222_2222};
    step(1, 0);
    chk(sv, 48'h1);
    chk(sa, 48'h2222_2222_2222);
    step(2, 0);
    chk(sv, 48'h0);
    chk(sa, 48'h2222_2222_2222);
    chk(wr, 48'h0);
    test_done;
  end
endmodule // perf_event_select_counter_tb_top
